/* File: hw/alu_ops_pkg.sv */
/*
 * Shared constants and types for the add/and execution datapath:
 * register offsets, opcode fields, flag layout, addressing limits.
 * Assumes a single pclk domain and an APB master with 32-bit data.
 */
package alu_ops_pkg;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] OFS_CTRL      = 8'h00;
	localparam logic [7:0] OFS_INSTR     = 8'h04;
	localparam logic [7:0] OFS_ACC       = 8'h08;
	localparam logic [7:0] OFS_STATUS    = 8'h0c;
	localparam logic [7:0] OFS_BANK      = 8'h10;
	localparam logic [7:0] OFS_INDEX     = 8'h14;
	localparam logic [7:0] OFS_MEM_ADDR  = 8'h18;
	localparam logic [7:0] OFS_MEM_DATA  = 8'h1c;

	localparam int        CTRL_EXT_BIT  = 0;
	localparam logic      CTRL_RESET    = 1'b0;
	localparam logic [7:0] ACC_RESET    = 8'h00;
	localparam logic [3:0] BANK_RESET   = 4'h0;
	localparam logic [11:0] ADDR_RESET  = 12'h000;
	localparam logic [15:0] INSTR_RESET = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// opcode fields
	localparam logic [7:0] OPC_ADD_IMMEDIATE = 8'h0f;
	localparam logic [7:0] OPC_AND_IMMEDIATE = 8'h0b;
	localparam logic [5:0] OPC_ADD_ACC_FILE  = 6'h09;
	localparam logic [5:0] OPC_ADD_ACC_CARRY = 6'h08;

	////////////////////////////////////////////////////////////////////////
	// addressing limits
	localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT  = 8'h80;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
	localparam logic [3:0] ACCESS_LO_BANK = 4'h0;

	typedef enum logic [1:0] {
		op_add,
		op_and,
		op_nop
	} alu_op_t;

	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} flags_t;

	localparam flags_t FLAGS_RESET = '0;

	typedef struct packed {
		logic [5:0] op6;
		logic       dest;
		logic       acc_sel;
		logic [7:0] lit;
	} instr_t;

endpackage

/* File: hw/add_and_alu.sv */
/*
 * Eight-bit adder/and unit with flag generation.
 * Purely combinational; the caller registers the results.
 */
module add_and_alu (
	input  wire alu_ops_pkg::alu_op_t op,
	input  wire logic [7:0]          opa,
	input  wire logic [7:0]          opb,
	input  wire logic                cin,
	input  wire alu_ops_pkg::flags_t flags_in,
	output logic [7:0]               result,
	output alu_ops_pkg::flags_t      flags_out
);

	logic [8:0] sum9;
	logic [4:0] low5;

	always_comb begin
		sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
		low5 = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
		flags_out = flags_in;
		result = opa;
		case (op)
			alu_ops_pkg::op_add: begin
				result = sum9[7:0];
				flags_out.c = sum9[8];
				flags_out.dc = low5[4];
				flags_out.ov = (opa[7] == opb[7]) && (sum9[7] != opa[7]);
				flags_out.n = sum9[7];
				flags_out.z = (sum9[7:0] == 8'h00);
			end
			alu_ops_pkg::op_and: begin
				result = opa & opb;
				flags_out.n = result[7];
				flags_out.z = (result == 8'h00);
			end
			default: begin
				result = opa;
			end
		endcase
	end

endmodule

/* File: hw/add_and_exec.sv */
/*
 * Four-phase execution core for add and and instructions, reached as an
 * APB slave. Holds accumulator, flags, bank select and data memory.
 * Assumes an APB master on pclk; one transfer at a time.
 */
module add_and_exec #(
	parameter int BANK_W = 4
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);

	localparam int AW = BANK_W + 8;
	localparam int DEPTH = 1 << AW;

	typedef enum logic [2:0] {
		st_idle,
		st_q1,
		st_q2,
		st_q3,
		st_q4
	} phase_t;

	phase_t               phase_ff;
	logic [7:0]           mem [DEPTH];
	alu_ops_pkg::instr_t  instr_ff;
	alu_ops_pkg::flags_t  flags_ff;
	alu_ops_pkg::flags_t  nxt_flags;
	alu_ops_pkg::alu_op_t op_ff;
	logic [7:0]           acc_ff;
	logic [BANK_W-1:0]    bank_ff;
	logic                 ext_en_ff;
	logic [AW-1:0]        index_ff;
	logic [AW-1:0]        mem_addr_ff;
	logic [AW-1:0]        ea_ff;
	logic [AW-1:0]        nxt_ea;
	logic [7:0]           opnd_ff;
	logic [7:0]           res_ff;
	logic [7:0]           nxt_res;
	logic                 to_file_ff;
	logic                 cin_ff;
	logic                 pready_ff;
	logic                 pslverr_ff;
	logic [31:0]          prdata_ff;
	logic                 done;
	logic                 start;
	logic                 wr;
	logic                 mapped;
	logic [31:0]          rd_val;

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;

	assign done = psel && penable && pready_ff;
	assign wr = done && pwrite;
	assign start = psel && penable && !pready_ff && pwrite
		&& paddr == alu_ops_pkg::OFS_INSTR && phase_ff == st_idle;

	////////////////////////////////////////////////////////////////////////
	// effective address
	always_comb begin
		if (instr_ff.acc_sel) begin
			nxt_ea = {bank_ff, instr_ff.lit};
		end else if (ext_en_ff
			&& instr_ff.lit <= alu_ops_pkg::INDEXED_LIMIT) begin
			nxt_ea = index_ff + {{BANK_W{1'b0}}, instr_ff.lit};
		end else if (!ext_en_ff
			&& instr_ff.lit < alu_ops_pkg::ACCESS_SPLIT) begin
			nxt_ea = {alu_ops_pkg::ACCESS_LO_BANK[BANK_W-1:0],
				instr_ff.lit};
		end else if (instr_ff.lit < alu_ops_pkg::ACCESS_SPLIT
			&& instr_ff.lit > alu_ops_pkg::INDEXED_LIMIT
			&& ext_en_ff) begin
			nxt_ea = {alu_ops_pkg::ACCESS_HI_BANK[BANK_W-1:0],
				instr_ff.lit};
		end else begin
			nxt_ea = {alu_ops_pkg::ACCESS_HI_BANK[BANK_W-1:0],
				instr_ff.lit};
		end
	end

	add_and_alu u_alu (
		.op        (op_ff),
		.opa       (acc_ff),
		.opb       (opnd_ff),
		.cin       (cin_ff),
		.flags_in  (flags_ff),
		.result    (nxt_res),
		.flags_out (nxt_flags)
	);

	////////////////////////////////////////////////////////////////////////
	// phase sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_ff <= st_idle;
		end else begin
			case (phase_ff)
				st_idle: if (start) phase_ff <= st_q1;
				st_q1:   phase_ff <= st_q2;
				st_q2:   phase_ff <= st_q3;
				st_q3:   phase_ff <= st_q4;
				st_q4:   phase_ff <= st_idle;
				default: phase_ff <= st_idle;
			endcase
		end
	end

	// q1 decode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_ff <= alu_ops_pkg::INSTR_RESET;
			op_ff <= alu_ops_pkg::op_nop;
			to_file_ff <= 1'b0;
			ea_ff <= alu_ops_pkg::ADDR_RESET[AW-1:0];
		end else if (start) begin
			instr_ff <= pwdata[15:0];
		end else if (phase_ff == st_q1) begin
			ea_ff <= nxt_ea;
			to_file_ff <= 1'b0;
			op_ff <= alu_ops_pkg::op_nop;
			if ({instr_ff.op6, instr_ff.dest, instr_ff.acc_sel}
				== alu_ops_pkg::OPC_ADD_IMMEDIATE) begin
				op_ff <= alu_ops_pkg::op_add;
			end else if ({instr_ff.op6, instr_ff.dest, instr_ff.acc_sel}
				== alu_ops_pkg::OPC_AND_IMMEDIATE) begin
				op_ff <= alu_ops_pkg::op_and;
			end else if (instr_ff.op6 == alu_ops_pkg::OPC_ADD_ACC_FILE
				|| instr_ff.op6 == alu_ops_pkg::OPC_ADD_ACC_CARRY) begin
				op_ff <= alu_ops_pkg::op_add;
				to_file_ff <= instr_ff.dest;
			end
		end
	end

	// q2 operand read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			opnd_ff <= 8'h00;
			cin_ff <= 1'b0;
		end else if (phase_ff == st_q2) begin
			cin_ff <= (instr_ff.op6 == alu_ops_pkg::OPC_ADD_ACC_CARRY)
				&& flags_ff.c;
			if (instr_ff.op6 == alu_ops_pkg::OPC_ADD_ACC_FILE
				|| instr_ff.op6 == alu_ops_pkg::OPC_ADD_ACC_CARRY) begin
				opnd_ff <= mem[ea_ff];
			end else begin
				opnd_ff <= instr_ff.lit;
			end
		end
	end

	// q3 process
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_ff <= 8'h00;
		end else if (phase_ff == st_q3) begin
			res_ff <= nxt_res;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// q4 write-back and software writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_ff <= alu_ops_pkg::ACC_RESET;
		end else if (phase_ff == st_q4 && op_ff != alu_ops_pkg::op_nop
			&& !to_file_ff) begin
			acc_ff <= res_ff;
		end else if (wr && paddr == alu_ops_pkg::OFS_ACC) begin
			acc_ff <= pwdata[7:0];
		end
	end

	// flags latch with the result at the end of q3, before q4 write-back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_ff <= alu_ops_pkg::FLAGS_RESET;
		end else if (phase_ff == st_q3) begin
			flags_ff <= nxt_flags;
		end else if (wr && paddr == alu_ops_pkg::OFS_STATUS) begin
			flags_ff <= pwdata[4:0];
		end
	end

	always_ff @(posedge pclk) begin
		if (phase_ff == st_q4 && op_ff != alu_ops_pkg::op_nop
			&& to_file_ff) begin
			mem[ea_ff] <= res_ff;
		end else if (wr && paddr == alu_ops_pkg::OFS_MEM_DATA) begin
			mem[mem_addr_ff] <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_en_ff <= alu_ops_pkg::CTRL_RESET;
			bank_ff <= alu_ops_pkg::BANK_RESET[BANK_W-1:0];
			index_ff <= alu_ops_pkg::ADDR_RESET[AW-1:0];
			mem_addr_ff <= alu_ops_pkg::ADDR_RESET[AW-1:0];
		end else if (wr) begin
			case (paddr)
				alu_ops_pkg::OFS_CTRL:
					ext_en_ff <= pwdata[alu_ops_pkg::CTRL_EXT_BIT];
				alu_ops_pkg::OFS_BANK:     bank_ff <= pwdata[BANK_W-1:0];
				alu_ops_pkg::OFS_INDEX:    index_ff <= pwdata[AW-1:0];
				alu_ops_pkg::OFS_MEM_ADDR: mem_addr_ff <= pwdata[AW-1:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb answer
	always_comb begin
		mapped = 1'b1;
		rd_val = 32'h0000_0000;
		case (paddr)
			alu_ops_pkg::OFS_CTRL:     rd_val[0] = ext_en_ff;
			alu_ops_pkg::OFS_INSTR:    rd_val[15:0] = instr_ff;
			alu_ops_pkg::OFS_ACC:      rd_val[7:0] = acc_ff;
			alu_ops_pkg::OFS_STATUS:   rd_val[4:0] = flags_ff;
			alu_ops_pkg::OFS_BANK:     rd_val[BANK_W-1:0] = bank_ff;
			alu_ops_pkg::OFS_INDEX:    rd_val[AW-1:0] = index_ff;
			alu_ops_pkg::OFS_MEM_ADDR: rd_val[AW-1:0] = mem_addr_ff;
			alu_ops_pkg::OFS_MEM_DATA: rd_val[7:0] = mem[mem_addr_ff];
			default:                   mapped = 1'b0;
		endcase
	end

	// instr writes hold pready low until q4 finishes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else if (psel && penable && !pready_ff) begin
			if (pwrite && paddr == alu_ops_pkg::OFS_INSTR) begin
				pready_ff <= (phase_ff == st_q4);
				pslverr_ff <= 1'b0;
				prdata_ff <= 32'h0000_0000;
			end else begin
				pready_ff <= 1'b1;
				pslverr_ff <= !mapped;
				prdata_ff <= pwrite ? 32'h0000_0000 : rd_val;
			end
		end else begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

endmodule

/* File: verif/add_and_alu_ops_sva.sv */
/*
 * Checker for the add/and execution block: APB answer timing and
 * error signalling.
 * Assumes one pclk domain with presetn async active low.
 */
module add_and_alu_ops_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////
	sequence s_first;
		psel && penable && !$past(penable);
	endsequence
	property p_in_access;
		pready |-> psel && penable;
	endproperty
	property p_pulse;
		pready |=> !pready;
	endproperty
	property p_write_zero;
		pready && pwrite |-> prdata == 32'h0;
	endproperty
	property p_reg_wait;
		s_first ##0 !(pwrite && paddr == alu_ops_pkg::OFS_INSTR)
			|-> !pready ##1 pready;
	endproperty
	property p_instr_wait;
		s_first ##0 (pwrite && paddr == alu_ops_pkg::OFS_INSTR)
			|-> !pready ##1 !pready [*4] ##1 pready;
	endproperty
	property p_unmapped;
		pready && paddr > alu_ops_pkg::OFS_MEM_DATA |-> pslverr;
	endproperty
	property p_mapped;
		pready && paddr <= alu_ops_pkg::OFS_MEM_DATA && paddr[1:0] == 2'h0
			|-> !pslverr;
	endproperty
	property p_err_ready;
		pslverr |-> pready;
	endproperty

	////////////////////////////////////////////////////////////
	a_in_access: assert property (p_in_access)
		else $error("pready outside access phase");
	a_pulse: assert property (p_pulse)
		else $error("pready longer than one cycle");
	a_write_zero: assert property (p_write_zero)
		else $error("prdata not zero on write");
	a_reg_wait: assert property (p_reg_wait)
		else $error("register access wait wrong");
	a_instr_wait: assert property (p_instr_wait)
		else $error("instruction execution length wrong");
	a_unmapped: assert property (p_unmapped)
		else $error("no error on unmapped address");
	a_mapped: assert property (p_mapped)
		else $error("error on mapped address");
	a_err_ready: assert property (p_err_ready)
		else $error("pslverr without pready");

	c_instr: cover property (s_first ##0 pwrite && paddr == 8'h04);
	c_err: cover property (pready && pslverr);
	c_read: cover property (pready && !pwrite);
endmodule

bind add_and_exec add_and_alu_ops_sva u_sva (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);

/* File: verif/tb_add_and_alu_ops.sv */
/*
 * Directed bench for the add/and execution block over APB.
 * Assumes the package offsets and the hand-over latencies.
 */
module tb_add_and_alu_ops;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic [7:0]  acc, st;
		logic [15:0] ins;
		logic [7:0]  eacc, est;
	} icase_t;
	typedef struct packed {
		logic [3:0]  ctrl, bank;
		logic [11:0] idx, ma;
		logic [7:0]  mv, acc, st;
		logic [15:0] ins;
		logic [7:0]  eacc, emem, est;
	} fcase_t;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	int          bad_count, checks_done;
	icase_t      ic [7] = '{48'h7f_00_0f01_80_1a, 48'hff_00_0f01_00_07,
		48'h10_00_0f15_25_00, 48'ha3_0b_0b5f_03_0b,
		48'ha3_1b_0b5c_00_0f, 48'h80_00_0bf0_80_10,
		48'h55_1f_0000_55_1f};
	fcase_t      fc [7] = '{96'h0_2_000_234_c2_17_00_2734_17_d9_10,
		96'h0_0_000_f90_10_05_00_2490_15_10_00,
		96'h0_1_000_102_02_4d_01_2102_50_02_02,
		96'h1_0_300_35f_40_40_00_265f_40_80_18,
		96'h1_0_300_f60_ff_00_01_2260_00_00_07,
		96'h0_3_000_045_11_22_00_2645_22_33_00,
		96'h1_5_300_520_01_fe_00_2120_ff_01_10};

	add_and_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	////////////////////////////////////////////////////////////
	task automatic end_sim;
		if (bad_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic cmp(string nm, logic [31:0] exp, logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic xfer(logic wr, logic [7:0] a, logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge pclk);
			n++;
		end
		if (n == 50)
			bad_count++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		logic [31:0] q;
		logic        e;
		xfer(1'b1, a, d, q, e);
	endtask
	task automatic chk(string nm, logic [7:0] a, logic [31:0] x, logic xe);
		logic [31:0] q;
		logic        e;
		xfer(1'b0, a, 32'h0, q, e);
		cmp(nm, x, q);
		cmp("pslverr", {31'h0, xe}, {31'h0, e});
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	initial begin
		#100000;
		bad_count++;
		end_sim;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		bad_count = 0;
		checks_done = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		chk("acc", alu_ops_pkg::OFS_ACC, 32'h0, 1'b0);
		chk("status", alu_ops_pkg::OFS_STATUS, 32'h0, 1'b0);
		foreach (ic[i]) begin
			wr(alu_ops_pkg::OFS_ACC, {24'h0, ic[i].acc});
			wr(alu_ops_pkg::OFS_STATUS, {24'h0, ic[i].st});
			wr(alu_ops_pkg::OFS_INSTR, {16'h0, ic[i].ins});
			chk("acc", 8'h08, {24'h0, ic[i].eacc}, 1'b0);
			chk("status", 8'h0c, {24'h0, ic[i].est}, 1'b0);
		end
		foreach (fc[i]) begin
			wr(alu_ops_pkg::OFS_CTRL, {28'h0, fc[i].ctrl});
			wr(alu_ops_pkg::OFS_BANK, {28'h0, fc[i].bank});
			wr(alu_ops_pkg::OFS_INDEX, {20'h0, fc[i].idx});
			wr(alu_ops_pkg::OFS_MEM_ADDR, {20'h0, fc[i].ma});
			wr(alu_ops_pkg::OFS_MEM_DATA, {24'h0, fc[i].mv});
			wr(alu_ops_pkg::OFS_ACC, {24'h0, fc[i].acc});
			wr(alu_ops_pkg::OFS_STATUS, {24'h0, fc[i].st});
			wr(alu_ops_pkg::OFS_INSTR, {16'h0, fc[i].ins});
			chk("acc", 8'h08, {24'h0, fc[i].eacc}, 1'b0);
			chk("mem", 8'h1c, {24'h0, fc[i].emem}, 1'b0);
			chk("status", 8'h0c, {24'h0, fc[i].est}, 1'b0);
		end
		chk("unmapped", 8'h20, 32'h0, 1'b1);
		end_sim;
	end
endmodule
